// ===== pkg/rse_map.svh
// Purpose: named constants for the rotate and sleep execution block
// Assumes: fourteen-bit instruction words, 8-bit data path
// Notes: included by bare name
`ifndef RSE_MAP_SVH
`define RSE_MAP_SVH
`define RSE_OP_HI 13
`define RSE_OP_LO 8
`define RSE_DEST_BIT 7
`define RSE_ADDR_HI 6
`define RSE_OP_RLC 6'h0d
`define RSE_OP_RRC 6'h0c
`define RSE_SLEEP_WORD 14'h0063
`define RSE_WDT_CLEAR 8'h00
`define RSE_PRESC_CLEAR 8'h00
`define RSE_WDT_STEP 8'h01
`define RSE_W_RESET 8'h00
`define RSE_FLAG_SET 1'h1
`define RSE_FLAG_CLR 1'h0
`define RSE_MSB 7
`define RSE_LSB 0
`endif

// ===== pkg/rse_pkg.sv
// Purpose: types for the rotate and sleep execution block
// Assumes: nothing beyond the map header
// Notes: four-phase instruction timing
package rse_pkg;
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } rse_phase_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h1,
    OP_ROT = 3'h2,
    OP_SLEEP = 3'h4
  } rse_op_t;
endpackage

// ===== design/rse_rotator.sv
// Purpose: one-bit rotate through carry, left or right
// Assumes: combinational, pure
// Notes: shared by both rotate instructions
`timescale 1ns/100ps
`default_nettype none
`include "rse_map.svh"
module rse_rotator #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] dataIn,
  input wire logic carryIn,
  input wire logic goLeft,
  output logic [WIDTH-1:0] dataOut,
  output logic carryOut
);
  always_comb begin
    if (goLeft) begin
      dataOut = {dataIn[WIDTH-2:0], carryIn};
      carryOut = dataIn[WIDTH-1];
    end else begin
      dataOut = {carryIn, dataIn[WIDTH-1:1]};
      carryOut = dataIn[0];
    end
  end
endmodule
`default_nettype wire

// ===== design/rse_exec.sv
// Purpose: execution of rotate-through-carry and power-down instructions
// Assumes: instruction word stable through the four phases of a cycle
// Notes: file register read and write use a simple port to the file store
// How it works
// - prefix 00 1101 rotates the chosen file register left via carry only.
// - prefix 00 1100 rotates the chosen file register right via carry only.
// - destination bit 0 writes the result to W, 1 writes it to the file.
// - a rotate takes one cycle: decode, read, compute, write in Q1..Q4.
// - the fixed word 00 0000 0110 0011 is the power-down instruction.
// - power-down loads the watchdog counter and prescaler with zero.
// - power-down clears the power-down flag and sets the time-out flag.
// - after power-down the core sleeps with the oscillator halted.
// - power-down decodes in Q1, idles in Q2 and Q3, sleeps in Q4.
`timescale 1ns/100ps
`default_nettype none
`include "rse_map.svh"
module rse_exec #(
  parameter int WIDTH = 8,
  parameter int IWIDTH = 14,
  parameter int AWIDTH = 7
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [IWIDTH-1:0] instrWord,
  input wire logic [WIDTH-1:0] fileRdData,
  input wire logic carryInit,
  input wire logic carryLoad,
  input wire logic wake,
  output logic [AWIDTH-1:0] fileAddr,
  output logic fileRdEn,
  output logic [WIDTH-1:0] fileWrData,
  output logic fileWrEn,
  output logic [WIDTH-1:0] workReg,
  output logic carry,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic [WIDTH-1:0] watchdog_counter,
  output logic [WIDTH-1:0] wdtPrescaler,
  output logic sleeping,
  output logic oscStop,
  output logic [3:0] phase
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // phase sequencer
  rse_pkg::rse_phase_t ph, next_ph;
  logic next_sleeping;
  logic next_oscStop;
  logic [3:0] next_phase;
  // decode
  rse_pkg::rse_op_t op, next_op;
  logic toLeft, next_toLeft;
  logic toFile, next_toFile;
  logic [AWIDTH-1:0] next_fileAddr;
  logic next_fileRdEn;
  // datapath
  logic [WIDTH-1:0] opnd, next_opnd;
  logic [WIDTH-1:0] res, next_res;
  logic resC, next_resC;
  // results
  logic next_fileWrEn;
  logic [WIDTH-1:0] next_fileWrData;
  logic [WIDTH-1:0] next_workReg;
  logic next_carry;
  // status and watchdog
  logic next_to, next_pd;
  logic [WIDTH-1:0] next_wdt, next_presc;
  logic wdtWrap;
  // shared
  logic [WIDTH-1:0] rotOut;
  logic rotC;
  logic [`RSE_OP_HI-`RSE_OP_LO:0] prefix;
  logic isRotate, isSleep, running;

  assign prefix = instrWord[`RSE_OP_HI:`RSE_OP_LO];

  rse_rotator #(.WIDTH(WIDTH)) u_rot (
    .dataIn(opnd),
    .carryIn(carry),
    .goLeft(toLeft),
    .dataOut(rotOut),
    .carryOut(rotC)
  );

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  assign isSleep = instrWord == `RSE_SLEEP_WORD;
  assign isRotate = (prefix == `RSE_OP_RLC) || (prefix == `RSE_OP_RRC);
  assign running = !sleeping;
  assign wdtWrap = &wdtPrescaler;

  // ------------------------------------------------------------
  // phase sequencer: next state
  // ------------------------------------------------------------
  always_comb begin
    next_ph = ph;
    next_sleeping = sleeping;
    if (sleeping) begin
      // halted core: phases frozen until woken
      if (wake) begin
        next_sleeping = 1'b0;
        next_ph = rse_pkg::PH_Q1;
      end
    end else begin
      unique case (ph)
        rse_pkg::PH_Q1: begin
          next_ph = rse_pkg::PH_Q2;
        end
        rse_pkg::PH_Q2: begin
          next_ph = rse_pkg::PH_Q3;
        end
        rse_pkg::PH_Q3: begin
          next_ph = rse_pkg::PH_Q4;
        end
        rse_pkg::PH_Q4: begin
          next_ph = rse_pkg::PH_Q1;
          if (op == rse_pkg::OP_SLEEP) begin
            next_sleeping = 1'b1;
          end
        end
      endcase
    end
    // the clock stop follows the sleep state edge for edge
    next_oscStop = next_sleeping;
    next_phase = next_ph;
  end

  // ------------------------------------------------------------
  // phase sequencer: registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph <= rse_pkg::PH_Q1;
      sleeping <= 1'b0;
      oscStop <= 1'b0;
      phase <= rse_pkg::PH_Q1;
    end else begin
      ph <= next_ph;
      sleeping <= next_sleeping;
      oscStop <= next_oscStop;
      phase <= next_phase;
    end
  end

  // ------------------------------------------------------------
  // decode: next state
  // ------------------------------------------------------------
  always_comb begin
    next_op = op;
    next_toLeft = toLeft;
    next_toFile = toFile;
    next_fileAddr = fileAddr;
    next_fileRdEn = 1'b0;
    if (running && (ph == rse_pkg::PH_Q1)) begin
      next_op = rse_pkg::OP_NONE;
      if (isSleep) begin
        next_op = rse_pkg::OP_SLEEP;
      end else if (prefix == `RSE_OP_RLC) begin
        next_op = rse_pkg::OP_ROT;
        next_toLeft = 1'b1;
      end else if (prefix == `RSE_OP_RRC) begin
        next_op = rse_pkg::OP_ROT;
        next_toLeft = 1'b0;
      end
      next_toFile = instrWord[`RSE_DEST_BIT];
      next_fileAddr = instrWord[`RSE_ADDR_HI:`RSE_LSB];
      // the store is read only for a rotate, never for power-down
      next_fileRdEn = isRotate;
    end
  end

  // ------------------------------------------------------------
  // decode: registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op <= rse_pkg::OP_NONE;
      toLeft <= 1'b0;
      toFile <= 1'b0;
      fileAddr <= '0;
      fileRdEn <= 1'b0;
    end else begin
      op <= next_op;
      toLeft <= next_toLeft;
      toFile <= next_toFile;
      fileAddr <= next_fileAddr;
      fileRdEn <= next_fileRdEn;
    end
  end

  // ------------------------------------------------------------
  // datapath: next state
  // ------------------------------------------------------------
  always_comb begin
    next_opnd = opnd;
    next_res = res;
    next_resC = resC;
    if (running && (op == rse_pkg::OP_ROT)) begin
      if (ph == rse_pkg::PH_Q2) begin
        next_opnd = fileRdData;
      end
      if (ph == rse_pkg::PH_Q3) begin
        next_res = rotOut;
        next_resC = rotC;
      end
    end
  end

  // ------------------------------------------------------------
  // datapath: registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opnd <= `RSE_W_RESET;
      res <= `RSE_W_RESET;
      resC <= 1'b0;
    end else begin
      opnd <= next_opnd;
      res <= next_res;
      resC <= next_resC;
    end
  end

  // ------------------------------------------------------------
  // results: next state
  // ------------------------------------------------------------
  always_comb begin
    next_workReg = workReg;
    next_fileWrData = fileWrData;
    next_fileWrEn = 1'b0;
    // a rotate's own carry write wins over a load on the same edge
    next_carry = carryLoad ? carryInit : carry;
    if (running && (ph == rse_pkg::PH_Q4) && (op == rse_pkg::OP_ROT)) begin
      next_carry = resC;
      if (toFile) begin
        next_fileWrData = res;
        next_fileWrEn = 1'b1;
      end else begin
        next_workReg = res;
      end
    end
  end

  // ------------------------------------------------------------
  // results: registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      workReg <= `RSE_W_RESET;
      fileWrData <= `RSE_W_RESET;
      fileWrEn <= 1'b0;
      carry <= 1'b0;
    end else begin
      workReg <= next_workReg;
      fileWrData <= next_fileWrData;
      fileWrEn <= next_fileWrEn;
      carry <= next_carry;
    end
  end

  // ------------------------------------------------------------
  // status and watchdog: next state
  // ------------------------------------------------------------
  always_comb begin
    next_to = timeout_flag_n;
    next_pd = powerdown_flag_n;
    next_wdt = watchdog_counter;
    next_presc = wdtPrescaler;
    if (running) begin
      // stand-in time base: the prescaler steps on every awake clock
      next_presc = WIDTH'(wdtPrescaler + `RSE_WDT_STEP);
      if (wdtWrap) begin
        next_wdt = WIDTH'(watchdog_counter + `RSE_WDT_STEP);
      end
      // the clear comes last so it beats a step on the same edge
      if ((ph == rse_pkg::PH_Q4) && (op == rse_pkg::OP_SLEEP)) begin
        next_wdt = `RSE_WDT_CLEAR;
        next_presc = `RSE_PRESC_CLEAR;
        next_pd = `RSE_FLAG_CLR;
        next_to = `RSE_FLAG_SET;
      end
    end
  end

  // ------------------------------------------------------------
  // status and watchdog: registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timeout_flag_n <= `RSE_FLAG_SET;
      powerdown_flag_n <= `RSE_FLAG_SET;
      watchdog_counter <= `RSE_WDT_CLEAR;
      wdtPrescaler <= `RSE_PRESC_CLEAR;
    end else begin
      timeout_flag_n <= next_to;
      powerdown_flag_n <= next_pd;
      watchdog_counter <= next_wdt;
      wdtPrescaler <= next_presc;
    end
  end
endmodule
`default_nettype wire

// ===== verification/rse_exec_chk.sv
// Purpose: port checks for rse_exec
// Assumes: default widths
// Notes: bind at the foot
`timescale 1ns/100ps
`default_nettype none
module rse_exec_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [13:0] instrWord,
  input wire logic [7:0] fileRdData,
  input wire logic fileRdEn,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrData,
  input wire logic [7:0] workReg,
  input wire logic carry,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic [7:0] watchdog_counter,
  input wire logic sleeping,
  input wire logic oscStop,
  input wire logic [3:0] phase
);
  wire go = phase == 4'h1 && !sleeping;
  wire d = instrWord[7];
  wire rl = go && instrWord[13:8] == 6'h0d;
  wire rr = go && instrWord[13:8] == 6'h0c;
  wire sl = go && instrWord == 14'h0063;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_left_w: assert property (rl && !d |-> ##4
    {carry, workReg} == {$past(fileRdData, 3), $past(carry, 2)})
    else $error("left rotate");
  a_right_f: assert property (rr && d |-> ##4 fileWrEn &&
    {fileWrData, carry} == {$past(carry, 2), $past(fileRdData, 3)})
    else $error("right rotate");
  a_read_q2: assert property (rl || rr |=>
    fileRdEn && phase == 4'h2) else $error("read phase");
  a_phase_walk: assert property (phase == 4'h2 |=>
    phase == 4'h4 ##1 phase == 4'h8) else $error("phase order");
  a_sleep_set: assert property (sl |-> ##4 sleeping &&
    !powerdown_flag_n && timeout_flag_n) else $error("sleep flags");
  a_wdt_clear: assert property (sl |-> ##4 watchdog_counter == 8'h00)
    else $error("wdt kept");
  a_osc_halt: assert property (sl |-> ##5 oscStop && sleeping)
    else $error("osc running");
  a_other_quiet: assert property (go && !rl && !rr && !sl |-> ##4
    !fileWrEn && !sleeping) else $error("other op acted");
endmodule
bind rse_exec rse_exec_chk rse_exec_chk_inst (.*);
`default_nettype wire

// ===== verification/rse_file_model.sv
// Purpose: file store beside rse_exec
// Assumes: bench offers the byte to read
// Notes: data inverted outside a read
`timescale 1ns/100ps
`default_nettype none
module rse_file_model (
  input wire logic fileRdEn,
  input wire logic [7:0] byteIn,
  output logic [7:0] fileRdData
);
  assign fileRdData = fileRdEn ? byteIn : ~byteIn;
endmodule
`default_nettype wire

// ===== verification/rse_exec_test.sv
// Purpose: self-checking bench for rse_exec
// Assumes: instructions start on a Q1 edge
// Notes: xorshift stimulus, fixed seed
`timescale 1ns/100ps
`default_nettype none
module rse_exec_test;
  logic clk = 1'b0, resetn = 1'b0, carryInit = 1'b0, carryLoad = 1'b0;
  logic wake = 1'b0, expC = 1'b0;
  logic [13:0] instrWord = 14'h0000;
  logic [7:0] fileByte = 8'h00, fileRdData, fileWrData, workReg;
  logic [7:0] watchdog_counter, wdtPrescaler;
  logic fileRdEn, fileWrEn, carry, timeout_flag_n, powerdown_flag_n;
  logic sleeping, oscStop;
  logic [7:0] wKeep;
  logic [6:0] fileAddr;
  logic [3:0] phase;
  logic [31:0] seed = 32'haafb2070;
  int n_fail = 0, cmp_count = 0;
  always #10 clk = ~clk;
  rse_exec rse_exec_inst (.*);
  rse_file_model rse_file_model_inst (.fileRdEn(fileRdEn), .byteIn(fileByte),
    .fileRdData(fileRdData));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input string nm, input logic [8:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic run(input logic [13:0] w, input logic [7:0] b);
    logic [8:0] e;
    logic [7:0] w0;
    logic rot, sl;
    e = w[8] ? {b, expC} : {b[0], expC, b[7:1]};
    w0 = workReg;
    rot = w[13:9] == 5'h06;
    sl = w == 14'h0063;
    instrWord <= w;
    fileByte <= b;
    repeat (4) @(posedge clk);
    instrWord <= 14'h0000;
    carryLoad <= !sl;
    carryInit <= seed[3];
    @(negedge clk);
    chk("carry", 9'(rot ? e[8] : expC), 9'(carry));
    chk("workReg", 9'(rot && !w[7] ? e[7:0] : w0), 9'(workReg));
    chk("fileWrEn", 9'(rot && w[7]), 9'(fileWrEn));
    if (rot && w[7]) begin
      chk("fileWrData", 9'(e[7:0]), 9'(fileWrData));
    end
    if (rot) begin
      chk("fileAddr", 9'(w[6:0]), 9'(fileAddr));
    end
    if (sl) begin
      chk("flags", 9'h005,
        9'({sleeping, powerdown_flag_n, timeout_flag_n}));
      chk("wdt", 9'h000, 9'(watchdog_counter | wdtPrescaler));
    end
    @(posedge clk);
    carryLoad <= 1'b0;
    expC = sl ? expC : carryInit;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    run(14'h0d26, 8'he6);
    run(14'h0726, 8'hff);
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      run({5'h06, seed[8:0]}, seed[16:9]);
    end
    run(14'h0063, 8'h5a);
    @(negedge clk);
    wKeep = workReg;
    @(posedge clk);
    instrWord <= 14'h0d26;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("oscStop", 9'h001, 9'(oscStop));
    chk("phaseAsleep", 9'h001, 9'(phase));
    chk("wdtAsleep", 9'h000, 9'(watchdog_counter | wdtPrescaler));
    chk("carryAsleep", 9'(expC), 9'(carry));
    chk("workRegAsleep", 9'(wKeep), 9'(workReg));
    @(posedge clk);
    instrWord <= 14'h0000;
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    run(14'h0d80, 8'h7f);
    summarize;
  end
endmodule
`default_nettype wire
